// ### rtl/genset_panel_pkg.sv
// Shared constants and types of the front-panel page and power control
package genset_panel_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] SENSOR_OFFSET = 8'h04;
	localparam logic [7:0] SLEEP_DELAY_OFFSET = 8'h08;
	localparam logic [7:0] POFF_DELAY_OFFSET = 8'h0C;
	localparam logic [7:0] STATUS_OFFSET = 8'h10;
	localparam logic [7:0] HOURS_OFFSET = 8'h14;
	localparam logic [7:0] MINUTES_OFFSET = 8'h18;

	// ==========================================================
	// Field layout and reset values
	localparam int CTRL_CFG_LSB = 0;
	localparam int STATUS_ASLEEP_BIT = 0;
	localparam int STATUS_HOLD_BIT = 1;
	localparam int STATUS_FAULT_BIT = 2;
	localparam int STATUS_PAGE_LSB = 4;
	localparam logic [1:0] CFG_RESET = 2'h0;
	localparam logic [5:0] SENSOR_PRESENT_RESET = 6'h3F;
	localparam logic [15:0] SLEEP_DELAY_RESET = 16'h012C;
	localparam logic [15:0] POFF_DELAY_RESET = 16'h0E10;

	// ==========================================================
	// Counting limits
	localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3B;
	localparam logic [5:0] MINUTE_LAST = 6'h3B;
	localparam logic [14:0] HOURS_MAX = 15'h7FFF;
	localparam int CURRENT_W = 12;

	// ==========================================================
	// Wiring configurations
	typedef enum logic [1:0] {
		three_phase_with_neutral_cfg = 2'b00,
		three_phase_no_neutral_cfg = 2'b01,
		two_phase_cfg = 2'b10,
		single_phase_cfg = 2'b11
	} wiring_t;

	// ==========================================================
	// Display pages
	typedef enum logic [3:0] {
		PG_ENGINE_1 = 4'b0000,
		PG_ENGINE_2 = 4'b0001,
		PG_ENGINE_3 = 4'b0010,
		PG_V_LINE_LINE = 4'b0011,
		PG_V_LINE_NEUTRAL = 4'b0100,
		PG_V_HALF = 4'b0101,
		PG_V_PHASE_PHASE = 4'b0110,
		PG_V_SINGLE = 4'b0111,
		PG_I_PHASES = 4'b1000,
		PG_I_NEUTRAL = 4'b1001,
		PG_FREQ_HOURS = 4'b1010
	} page_t;

endpackage

// ### rtl/neutral_if.sv
// Link between the panel logic and the neutral current calculator
`timescale 1ns/10ps
`default_nettype none
interface neutral_if;
	logic [11:0] ia;
	logic [11:0] ib;
	logic [11:0] ic;
	logic start;
	logic busy;
	logic done;
	logic [11:0] neutral;

	modport requester (output ia, output ib, output ic, output start,
		input busy, input done, input neutral);
	modport solver (input ia, input ib, input ic, input start,
		output busy, output done, output neutral);
endinterface
`default_nettype wire

// ### rtl/neutral_current_calc.sv
// Neutral current magnitude from three phase currents at 120 degrees
`timescale 1ns/10ps
`default_nettype none
module neutral_current_calc (
	input wire logic clk,
	input wire logic rstn,
	neutral_if.solver nif
);
	// ==========================================================
	// Squared magnitude of the phasor sum
	logic [25:0] sq_ff;
	logic [11:0] root_ff;
	logic [11:0] bit_ff;
	logic busy_ff;
	logic done_ff;
	wire [25:0] a = {14'h0000, nif.ia};
	wire [25:0] b = {14'h0000, nif.ib};
	wire [25:0] c = {14'h0000, nif.ic};
	// Sum of squares minus cross terms is never negative
	wire [25:0] mag_sq = a * a + b * b + c * c - a * b - b * c - c * a;
	wire [11:0] trial = root_ff | bit_ff;
	wire [25:0] trial_sq = {14'h0000, trial} * {14'h0000, trial};
	wire last_step = bit_ff[0];

	// ==========================================================
	// Bitwise square root, one result bit per clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sq_ff <= 26'h000_0000;
			root_ff <= 12'h000;
			bit_ff <= 12'h000;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (nif.start && !busy_ff) begin
			sq_ff <= mag_sq;
			root_ff <= 12'h000;
			bit_ff <= 12'h800;
			busy_ff <= 1'b1;
			done_ff <= 1'b0;
		end else if (busy_ff) begin
			if (trial_sq <= sq_ff) begin
				root_ff <= trial;
			end
			bit_ff <= bit_ff >> 1;
			busy_ff <= !last_step;
			done_ff <= last_step;
		end else begin
			done_ff <= 1'b0;
		end
	end

	assign nif.busy = busy_ff;
	assign nif.done = done_ff;
	assign nif.neutral = root_ff;
endmodule
`default_nettype wire

// ### rtl/genset_panel.sv
// Front-panel sleep, auto power-off, page cycling and running-hours logic
`timescale 1ns/10ps
`default_nettype none
module genset_panel (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic sec_tick,
	input wire logic mode_stop,
	input wire logic mode_auto,
	input wire logic set_stopped,
	input wire logic engine_running,
	input wire logic remote_start_request,
	input wire logic tariff_start_request,
	input wire logic calendar_active,
	input wire logic [15:0] logic_inputs,
	input wire logic pc_activity,
	input wire logic any_key,
	input wire logic key_voltage,
	input wire logic key_current,
	input wire logic key_freq,
	input wire logic key_engine,
	input wire logic key_exit,
	input wire logic power_key,
	input wire logic fault_active,
	input wire logic [5:0] sensor_fault,
	input wire logic [11:0] phase_a_current,
	input wire logic [11:0] phase_b_current,
	input wire logic [11:0] phase_c_current,
	output logic backlight_on,
	output logic power_hold,
	output logic force_stop,
	output logic restart_init,
	output logic skip_language,
	output logic [3:0] page,
	output logic [2:0] line_blank,
	output logic [2:0] value_blank,
	output logic [11:0] neutral_current,
	output logic [14:0] run_hours,
	output logic [5:0] run_minutes
);
	// ==========================================================
	// Page stepping
	function automatic genset_panel_pkg::page_t voltage_step(
		input genset_panel_pkg::wiring_t cfg,
		input genset_panel_pkg::page_t cur);
		genset_panel_pkg::page_t nxt;
		nxt = genset_panel_pkg::PG_V_LINE_LINE;
		unique case (cfg)
			genset_panel_pkg::three_phase_with_neutral_cfg: begin
				nxt = (cur == genset_panel_pkg::PG_V_LINE_LINE) ?
					genset_panel_pkg::PG_V_LINE_NEUTRAL : genset_panel_pkg::PG_V_LINE_LINE;
			end
			genset_panel_pkg::three_phase_no_neutral_cfg: begin
				nxt = genset_panel_pkg::PG_V_LINE_LINE;
			end
			genset_panel_pkg::two_phase_cfg: begin
				nxt = (cur == genset_panel_pkg::PG_V_HALF) ?
					genset_panel_pkg::PG_V_PHASE_PHASE : genset_panel_pkg::PG_V_HALF;
			end
			genset_panel_pkg::single_phase_cfg: begin
				nxt = genset_panel_pkg::PG_V_SINGLE;
			end
		endcase
		return nxt;
	endfunction

	function automatic genset_panel_pkg::page_t current_step(
		input genset_panel_pkg::wiring_t cfg,
		input genset_panel_pkg::page_t cur);
		genset_panel_pkg::page_t nxt;
		nxt = genset_panel_pkg::PG_I_PHASES;
		if (cfg == genset_panel_pkg::three_phase_with_neutral_cfg &&
			cur == genset_panel_pkg::PG_I_PHASES) begin
			nxt = genset_panel_pkg::PG_I_NEUTRAL;
		end
		return nxt;
	endfunction

	function automatic genset_panel_pkg::page_t engine_step(
		input genset_panel_pkg::page_t cur);
		genset_panel_pkg::page_t nxt;
		nxt = genset_panel_pkg::PG_ENGINE_1;
		if (cur == genset_panel_pkg::PG_ENGINE_1) begin
			nxt = genset_panel_pkg::PG_ENGINE_2;
		end else if (cur == genset_panel_pkg::PG_ENGINE_2) begin
			nxt = genset_panel_pkg::PG_ENGINE_3;
		end
		return nxt;
	endfunction

	// ==========================================================
	// Registers
	logic [1:0] cfg_ff;
	logic [5:0] sensor_present_ff;
	logic [15:0] sleep_delay_ff;
	logic [15:0] poff_delay_ff;
	logic [31:0] rdata_ff;
	logic [15:0] inputs_prev_ff;
	logic [4:0] keys_prev_ff;
	logic [15:0] idle_ff;
	logic [15:0] stop_time_ff;
	logic asleep_ff;
	logic backlight_ff;
	logic hold_ff;
	logic fault_seen_ff;
	logic force_stop_ff;
	logic restart_ff;
	logic skip_lang_ff;
	genset_panel_pkg::page_t page_ff;
	genset_panel_pkg::page_t nxt_page;
	logic [2:0] line_blank_ff;
	logic [2:0] value_blank_ff;
	logic [11:0] neutral_ff;
	logic [5:0] sec_count_ff;
	logic [5:0] minutes_ff;
	logic [14:0] hours_ff;

	// ==========================================================
	// Register decode
	wire wr_ctrl = wr && addr == genset_panel_pkg::CTRL_OFFSET;
	wire wr_sensor = wr && addr == genset_panel_pkg::SENSOR_OFFSET;
	wire wr_sleep = wr && addr == genset_panel_pkg::SLEEP_DELAY_OFFSET;
	wire wr_poff = wr && addr == genset_panel_pkg::POFF_DELAY_OFFSET;
	wire [31:0] status_word = {24'h00_0000, page_ff, 1'b0, fault_seen_ff, hold_ff, asleep_ff};
	wire [31:0] rd_mux =
		(addr == genset_panel_pkg::CTRL_OFFSET) ? {30'h0000_0000, cfg_ff} :
		(addr == genset_panel_pkg::SENSOR_OFFSET) ? {26'h000_0000, sensor_present_ff} :
		(addr == genset_panel_pkg::SLEEP_DELAY_OFFSET) ? {16'h0000, sleep_delay_ff} :
		(addr == genset_panel_pkg::POFF_DELAY_OFFSET) ? {16'h0000, poff_delay_ff} :
		(addr == genset_panel_pkg::STATUS_OFFSET) ? status_word :
		(addr == genset_panel_pkg::HOURS_OFFSET) ? {17'h0_0000, hours_ff} :
		(addr == genset_panel_pkg::MINUTES_OFFSET) ? {26'h000_0000, minutes_ff} :
		32'h0000_0000;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_ff <= genset_panel_pkg::CFG_RESET;
			sensor_present_ff <= genset_panel_pkg::SENSOR_PRESENT_RESET;
			sleep_delay_ff <= genset_panel_pkg::SLEEP_DELAY_RESET;
			poff_delay_ff <= genset_panel_pkg::POFF_DELAY_RESET;
			rdata_ff <= 32'h0000_0000;
		end else begin
			if (wr_ctrl) cfg_ff <= wdata[genset_panel_pkg::CTRL_CFG_LSB +: 2];
			if (wr_sensor) sensor_present_ff <= wdata[5:0];
			if (wr_sleep) sleep_delay_ff <= wdata[15:0];
			if (wr_poff) poff_delay_ff <= wdata[15:0];
			rdata_ff <= rd ? rd_mux : 32'h0000_0000;
		end
	end

	// ==========================================================
	// Activity and sleep
	wire input_change = |(logic_inputs ^ inputs_prev_ff);
	wire [4:0] keys_now = {key_exit, key_engine, key_freq, key_current, key_voltage};
	wire [4:0] key_press = keys_now & ~keys_prev_ff;
	wire activity = input_change || pc_activity || any_key || (|key_press);
	// standby means no start demand of any kind
	wire standby = set_stopped && !remote_start_request && !tariff_start_request &&
		!calendar_active;
	wire sleep_ok = mode_stop || (mode_auto && standby);
	wire idle_done = idle_ff >= sleep_delay_ff;
	wire poff_done = stop_time_ff >= poff_delay_ff;
	wire power_press = power_key && !hold_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			inputs_prev_ff <= 16'h0000;
			keys_prev_ff <= 5'h00;
			idle_ff <= 16'h0000;
		end else begin
			inputs_prev_ff <= logic_inputs;
			keys_prev_ff <= keys_now;
			// idle time restarts on any activity
			if (activity || !sleep_ok) begin
				idle_ff <= 16'h0000;
			end else if (sec_tick && !idle_done) begin
				idle_ff <= idle_ff + 16'h0001;
			end
		end
	end

	// Fault paths are deliberately absent from the wake term
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			asleep_ff <= 1'b0;
			backlight_ff <= 1'b1;
		end else if (activity || !sleep_ok || !hold_ff) begin
			asleep_ff <= 1'b0;
			backlight_ff <= hold_ff;
		end else if (idle_done) begin
			asleep_ff <= 1'b1;
			backlight_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Auto power-off and restart
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stop_time_ff <= 16'h0000;
			hold_ff <= 1'b1;
			fault_seen_ff <= 1'b0;
			force_stop_ff <= 1'b0;
			restart_ff <= 1'b0;
			skip_lang_ff <= 1'b0;
		end else begin
			// fault forces Stop and blocks power-off
			force_stop_ff <= fault_active;
			if (fault_active) begin
				fault_seen_ff <= 1'b1;
			end else if (power_press) begin
				fault_seen_ff <= 1'b0;
			end
			// delay runs only in Stop mode
			if (!mode_stop || activity || !hold_ff) begin
				stop_time_ff <= 16'h0000;
			end else if (sec_tick && !poff_done) begin
				stop_time_ff <= stop_time_ff + 16'h0001;
			end
			restart_ff <= power_press;
			if (power_press) begin
				hold_ff <= 1'b1;
				skip_lang_ff <= 1'b1;
			end else if (mode_stop && poff_done && !fault_seen_ff && !fault_active) begin
				// counters and calendar are not cleared here
				hold_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Page selection
	always_comb begin
		nxt_page = page_ff;
		if (key_press[4] || restart_ff) begin
			nxt_page = genset_panel_pkg::PG_ENGINE_1;
		end else if (key_press[0]) begin
			nxt_page = voltage_step(genset_panel_pkg::wiring_t'(cfg_ff), page_ff);
		end else if (key_press[1]) begin
			nxt_page = current_step(genset_panel_pkg::wiring_t'(cfg_ff), page_ff);
		end else if (key_press[2]) begin
			nxt_page = genset_panel_pkg::PG_FREQ_HOURS;
		end else if (key_press[3]) begin
			nxt_page = engine_step(page_ff);
		end
	end

	// Line n of an engine page maps to sensor n, or n+3 on metric and imperial pages
	wire eng_page = page_ff == genset_panel_pkg::PG_ENGINE_1 ||
		page_ff == genset_panel_pkg::PG_ENGINE_2 || page_ff == genset_panel_pkg::PG_ENGINE_3;
	wire upper_set = page_ff != genset_panel_pkg::PG_ENGINE_1;
	wire [2:0] line_present = upper_set ? sensor_present_ff[5:3] : sensor_present_ff[2:0];
	wire [2:0] line_fault = upper_set ? sensor_fault[5:3] : sensor_fault[2:0];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			page_ff <= genset_panel_pkg::PG_ENGINE_1;
			line_blank_ff <= 3'h0;
			value_blank_ff <= 3'h0;
		end else begin
			page_ff <= nxt_page;
			line_blank_ff <= eng_page ? ~line_present : 3'h0;
			value_blank_ff <= eng_page ? (~line_present | line_fault) : 3'h0;
		end
	end

	// ==========================================================
	// Neutral current
	neutral_if nif();
	assign nif.ia = phase_a_current;
	assign nif.ib = phase_b_current;
	assign nif.ic = phase_c_current;
	assign nif.start = sec_tick;

	neutral_current_calc u_neutral (
		.clk(clk),
		.rstn(rstn),
		.nif(nif)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			neutral_ff <= 12'h000;
		end else if (nif.done) begin
			neutral_ff <= nif.neutral;
		end
	end

	// ==========================================================
	// Running hours
	wire minute_end = sec_tick && engine_running &&
		sec_count_ff == genset_panel_pkg::SECONDS_PER_MINUTE;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sec_count_ff <= 6'h00;
			minutes_ff <= 6'h00;
			hours_ff <= 15'h0000;
		end else if (sec_tick && engine_running) begin
			sec_count_ff <= minute_end ? 6'h00 : sec_count_ff + 6'h01;
			if (minute_end) begin
				if (minutes_ff == genset_panel_pkg::MINUTE_LAST) begin
					minutes_ff <= 6'h00;
					if (hours_ff != genset_panel_pkg::HOURS_MAX) begin
						hours_ff <= hours_ff + 15'h0001;
					end
				end else begin
					minutes_ff <= minutes_ff + 6'h01;
				end
			end
		end
	end

	// ==========================================================
	// Outputs
	assign rdata = rdata_ff;
	assign backlight_on = backlight_ff;
	assign power_hold = hold_ff;
	assign force_stop = force_stop_ff;
	assign restart_init = restart_ff;
	assign skip_language = skip_lang_ff;
	assign page = page_ff;
	assign line_blank = line_blank_ff;
	assign value_blank = value_blank_ff;
	assign neutral_current = neutral_ff;
	assign run_hours = hours_ff;
	assign run_minutes = minutes_ff;
endmodule
`default_nettype wire

// ### verification/genset_panel_properties.sv
// Concurrent checks on the panel control ports
`timescale 1ns/10ps
`default_nettype none
module genset_panel_properties (
	input wire logic clk,
	input wire logic rstn,
	input wire logic mode_stop,
	input wire logic mode_auto,
	input wire logic set_stopped,
	input wire logic [15:0] logic_inputs,
	input wire logic key_voltage,
	input wire logic key_current,
	input wire logic key_freq,
	input wire logic key_engine,
	input wire logic key_exit,
	input wire logic power_key,
	input wire logic fault_active,
	input wire logic backlight_on,
	input wire logic power_hold,
	input wire logic force_stop,
	input wire logic restart_init,
	input wire logic skip_language,
	input wire logic [3:0] page,
	input wire logic [14:0] run_hours,
	input wire logic [5:0] run_minutes
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// ==========
	// Key presses, exit wins over all others
	sequence s_volt;
		!restart_init && $rose(key_voltage) && !$rose(key_exit);
	endsequence
	sequence s_cur;
		!restart_init && $rose(key_current) && !$rose(key_exit) && !$rose(key_voltage);
	endsequence
	sequence s_hz;
		!restart_init && $rose(key_freq) && !$rose(key_exit) && !$rose(key_voltage)
			&& !$rose(key_current);
	endsequence
	sequence s_eng;
		!restart_init && $rose(key_engine) && !key_exit && !key_voltage && !key_current
			&& !key_freq;
	endsequence

	// ==========
	// Properties
	property p_force_stop;
		fault_active |=> force_stop;
	endproperty
	property p_restart;
		!power_hold && power_key |=> power_hold && restart_init && skip_language;
	endproperty
	property p_restart_pulse;
		restart_init |=> !restart_init;
	endproperty
	property p_exit_page;
		$rose(key_exit) |=> page == genset_panel_pkg::PG_ENGINE_1;
	endproperty
	property p_volt_page;
		s_volt |=> page inside {[genset_panel_pkg::PG_V_LINE_LINE:genset_panel_pkg::PG_V_SINGLE]};
	endproperty
	property p_cur_page;
		s_cur |=> page inside {genset_panel_pkg::PG_I_PHASES, genset_panel_pkg::PG_I_NEUTRAL};
	endproperty
	property p_freq_page;
		s_hz |=> page == genset_panel_pkg::PG_FREQ_HOURS;
	endproperty
	property p_eng_step;
		s_eng ##0 page == genset_panel_pkg::PG_ENGINE_1 |=> page == genset_panel_pkg::PG_ENGINE_2;
	endproperty
	property p_min_range;
		run_minutes <= genset_panel_pkg::MINUTE_LAST;
	endproperty
	property p_hour_step;
		$changed(run_hours) |-> run_minutes == 6'h00
			&& $past(run_minutes) == genset_panel_pkg::MINUTE_LAST
			&& run_hours == $past(run_hours) + 15'h0001;
	endproperty
	property p_wake_input;
		power_hold && logic_inputs != $past(logic_inputs) |-> ##[1:2] backlight_on;
	endproperty
	property p_sleep_allowed;
		$fell(backlight_on) |-> $past(mode_stop || (mode_auto && set_stopped));
	endproperty
	property p_poff_stop;
		$fell(power_hold) |-> $past(mode_stop);
	endproperty

	a_force_stop: assert property (p_force_stop) else $error("fault did not force stop");
	a_restart: assert property (p_restart) else $error("power key restart missing");
	a_restart_pulse: assert property (p_restart_pulse) else $error("restart pulse too long");
	a_exit_page: assert property (p_exit_page) else $error("exit did not show page 0");
	a_volt_page: assert property (p_volt_page) else $error("voltage key page wrong");
	a_cur_page: assert property (p_cur_page) else $error("current key page wrong");
	a_freq_page: assert property (p_freq_page) else $error("frequency key page wrong");
	a_eng_step: assert property (p_eng_step) else $error("engine key did not step");
	a_min_range: assert property (p_min_range) else $error("minutes above limit");
	a_hour_step: assert property (p_hour_step) else $error("hours changed wrongly");
	a_wake_input: assert property (p_wake_input) else $error("input change did not wake");
	a_sleep_allowed: assert property (p_sleep_allowed) else $error("sleep in wrong mode");
	a_poff_stop: assert property (p_poff_stop) else $error("power off outside stop");
endmodule

bind genset_panel genset_panel_properties chk_i (.clk, .rstn, .mode_stop, .mode_auto,
	.set_stopped, .logic_inputs, .key_voltage, .key_current, .key_freq, .key_engine,
	.key_exit, .power_key, .fault_active, .backlight_on, .power_hold, .force_stop,
	.restart_init, .skip_language, .page, .run_hours, .run_minutes);
`default_nettype wire

// ### verification/genset_far_side.sv
// Far-side model: calendar second tick, shortened for simulation
`timescale 1ns/10ps
`default_nettype none
module genset_far_side #(
	parameter int TICK_CYCLES = 16
) (
	input wire logic clk,
	input wire logic rstn,
	output logic sec_tick
);
	logic [7:0] div_ff;
	logic [7:0] nxt_div;
	assign nxt_div = (div_ff == 8'(TICK_CYCLES - 1)) ? 8'h00 : div_ff + 8'h01;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_ff <= 8'h00;
			sec_tick <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			sec_tick <= (nxt_div == 8'h00);
		end
	end
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench of the panel page and power control
`timescale 1ns/10ps
`default_nettype none
module tb;
	// Reset starts high and falls by NBA so the asynchronous reset edge is seen
	logic clk = 1'b0, rstn = 1'b1, wr = 1'b0, rd = 1'b0, any_key = 1'b0, power_key = 1'b0;
	logic pc_activity = 1'b0;
	logic [2:0] demand = 3'h0;
	logic mode_stop = 1'b1, mode_auto = 1'b0, set_stopped = 1'b1, engine_running = 1'b0;
	logic fault_active = 1'b0, sec_tick;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [15:0] logic_inputs = 16'h0000;
	logic [4:0] keys = 5'h00;
	logic [5:0] sensor_fault = 6'h00, run_minutes;
	logic [11:0] ia = 12'h000, ib = 12'h000, ic = 12'h000, neutral_current;
	logic backlight_on, power_hold, force_stop, restart_init, skip_language;
	logic [3:0] page;
	logic [2:0] line_blank, value_blank;
	logic [14:0] run_hours;
	int bad_count = 0, cmp_count = 0;
	// Rows: wiring, key (0 V, 1 A, 2 Hz, 3 engine, 4 exit), page expected
	logic [11:0] rows [24] = '{12'h003, 12'h004, 12'h003, 12'h018, 12'h019, 12'h018,
		12'h02A, 12'h040, 12'h031, 12'h032, 12'h030, 12'h103, 12'h103, 12'h118, 12'h118,
		12'h205, 12'h206, 12'h205, 12'h218, 12'h218, 12'h307, 12'h307, 12'h318, 12'h318};

	genset_panel uut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .sec_tick, .mode_stop,
		.mode_auto, .set_stopped, .engine_running, .remote_start_request(demand[0]),
		.tariff_start_request(demand[1]), .calendar_active(demand[2]), .logic_inputs,
		.pc_activity, .any_key, .key_voltage(keys[0]), .key_current(keys[1]),
		.key_freq(keys[2]), .key_engine(keys[3]), .key_exit(keys[4]), .power_key,
		.fault_active, .sensor_fault, .phase_a_current(ia), .phase_b_current(ib),
		.phase_c_current(ic), .backlight_on, .power_hold, .force_stop, .restart_init,
		.skip_language, .page, .line_blank, .value_blank, .neutral_current, .run_hours,
		.run_minutes);
	genset_far_side #(.TICK_CYCLES(16)) far (.clk, .rstn, .sec_tick);

	// ==========
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string w);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e, w);
	endtask
	task automatic press(input int k);
		@(posedge clk);
		keys[k] <= 1'b1;
		@(posedge clk);
		keys[k] <= 1'b0;
		#1;
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge sec_tick);
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic neu(input logic [11:0] a, b, c, e);
		@(posedge clk);
		ia <= a;
		ib <= b;
		ic <= c;
		ticks(2);
		chk(neutral_current, e, "neutral");
	endtask

	initial begin
		forever #5 clk = ~clk;
	end
	// Whole run is about 3700 ticks of 16 cycles
	initial begin
		repeat (70000) @(posedge clk);
		bad_count++;
		stop_test();
	end

	// ==========
	// Main sequence
	initial begin
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rchk(genset_panel_pkg::CTRL_OFFSET, 32'h0000_0000, "ctrl");
		rchk(genset_panel_pkg::SENSOR_OFFSET, 32'h0000_003F, "sensor");
		rchk(genset_panel_pkg::SLEEP_DELAY_OFFSET, 32'h0000_012C, "sleep_delay");
		rchk(genset_panel_pkg::POFF_DELAY_OFFSET, 32'h0000_0E10, "poff_delay");
		rchk(8'h20, 32'h0000_0000, "unmapped");
		chk(page, 4'h0, "reset page");
		foreach (rows[i]) begin
			if (i == 0 || rows[i][9:8] != rows[i - 1][9:8]) begin
				wreg(genset_panel_pkg::CTRL_OFFSET, {30'h0, rows[i][9:8]});
			end
			press(int'(rows[i][7:4]));
			chk(page, rows[i][3:0], "page");
		end
		// Fuel sensor undeclared, speed sensor faulty
		wreg(genset_panel_pkg::SENSOR_OFFSET, 32'h0000_003E);
		sensor_fault <= 6'h02;
		press(4);
		ticks(0);
		chk(line_blank, 3'h1, "line_blank");
		chk(value_blank, 3'h3, "value_blank");
		press(3);
		ticks(0);
		chk({line_blank, value_blank}, 6'h00, "blanks page 2");
		neu(12'h064, 12'h064, 12'h064, 12'h000);
		neu(12'h0C8, 12'h064, 12'h000, 12'h0AD);
		neu(12'h000, 12'h000, 12'h12C, 12'h12C);
		// Sleep and wake in Stop and Auto
		wreg(genset_panel_pkg::SLEEP_DELAY_OFFSET, 32'h0000_0002);
		ticks(4);
		chk(backlight_on, 1'b0, "asleep");
		@(posedge clk);
		logic_inputs <= 16'h0001;
		ticks(0);
		chk(backlight_on, 1'b1, "input wake");
		@(posedge clk);
		mode_stop <= 1'b0;
		mode_auto <= 1'b1;
		set_stopped <= 1'b0;
		ticks(4);
		chk(backlight_on, 1'b1, "running stays lit");
		@(posedge clk);
		set_stopped <= 1'b1;
		// Each start demand alone must keep the panel lit
		for (int d = 0; d < 3; d++) begin
			demand <= 3'(1 << d);
			ticks(4);
			chk(backlight_on, 1'b1, "start demand lit");
			@(posedge clk);
		end
		demand <= 3'h0;
		ticks(4);
		chk(backlight_on, 1'b0, "standby asleep");
		@(posedge clk);
		any_key <= 1'b1;
		@(posedge clk);
		any_key <= 1'b0;
		ticks(0);
		chk(backlight_on, 1'b1, "key wake");
		ticks(4);
		chk(backlight_on, 1'b0, "asleep again");
		@(posedge clk);
		pc_activity <= 1'b1;
		@(posedge clk);
		pc_activity <= 1'b0;
		ticks(0);
		chk(backlight_on, 1'b1, "pc wake");
		// Automatic power-off and restart
		@(posedge clk);
		mode_stop <= 1'b1;
		mode_auto <= 1'b0;
		wreg(genset_panel_pkg::POFF_DELAY_OFFSET, 32'h0000_0003);
		ticks(5);
		chk(power_hold, 1'b0, "powered off");
		@(posedge clk);
		power_key <= 1'b1;
		@(posedge clk);
		power_key <= 1'b0;
		#1;
		chk({power_hold, restart_init, skip_language}, 3'h7, "restart");
		ticks(0);
		chk({restart_init, page}, 5'h00, "restart page");
		rchk(genset_panel_pkg::CTRL_OFFSET, 32'h0000_0003, "ctrl kept");
		// Fault keeps the unit powered and dark
		@(posedge clk);
		fault_active <= 1'b1;
		ticks(5);
		chk({power_hold, force_stop}, 2'h3, "fault hold");
		chk(backlight_on, 1'b0, "fault no wake");
		rchk(genset_panel_pkg::STATUS_OFFSET, 32'h0000_0007, "status");
		// Running hours, 3600 ticks to one hour
		@(posedge clk);
		fault_active <= 1'b0;
		mode_stop <= 1'b0;
		mode_auto <= 1'b1;
		set_stopped <= 1'b0;
		engine_running <= 1'b1;
		ticks(60);
		chk(run_minutes, 6'h01, "minutes");
		ticks(3540);
		chk({run_hours, run_minutes}, 21'h00_0040, "hour wrap");
		rchk(genset_panel_pkg::HOURS_OFFSET, 32'h0000_0001, "hours reg");
		rchk(genset_panel_pkg::MINUTES_OFFSET, 32'h0000_0000, "minutes reg");
		stop_test();
	end
endmodule
`default_nettype wire
